// ---- hw/i2cms_pkg.sv ----
// Constants, register map and types of the I2C master sequencer.
// Assumes one 200 MHz clock and an APB slave with 32-bit data.
package i2cms_pkg;

	// ------------------------------------------------------------
	// Register indices and APB byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] CR_IDX = 8'h10;
	localparam logic [7:0] CCR_IDX = 8'h11;
	localparam logic [7:0] IN_IDX = 8'h06;
	localparam logic [7:0] SR1_IDX = 8'h07;
	localparam logic [7:0] SR2_IDX = 8'h08;
	localparam logic [7:0] OUT_IDX = 8'h15;
	localparam logic [9:0] CR_ADDR = {CR_IDX, 2'h0};
	localparam logic [9:0] CCR_ADDR = {CCR_IDX, 2'h0};
	localparam logic [9:0] IN_ADDR = {IN_IDX, 2'h0};
	localparam logic [9:0] SR1_ADDR = {SR1_IDX, 2'h0};
	localparam logic [9:0] SR2_ADDR = {SR2_IDX, 2'h0};
	localparam logic [9:0] OUT_ADDR = {OUT_IDX, 2'h0};
	localparam logic [7:0] CR_RST = 8'h00;
	localparam logic [7:0] CCR_RST = 8'h00;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int PE_POS = 5;
	localparam int SR1_EVF = 7;
	localparam int SR1_TEN_BIT_HEADER_SENT_FLAG = 6;
	localparam int SR1_TRA = 5;
	localparam int SR1_BUSY = 4;
	localparam int SR1_BTF = 3;
	localparam int SR1_MSL = 1;
	localparam int SR1_SB = 0;
	localparam int SR2_AF = 4;
	localparam int SR2_ARBITRATION_LOST_FLAG = 2;
	localparam int SR2_BUS_ERROR_FLAG = 1;

	// ------------------------------------------------------------
	// Protocol and divider constants
	// ------------------------------------------------------------
	localparam logic [4:0] HDR10 = 5'h1E;
	localparam logic [3:0] LAST_BIT = 4'h8;
	localparam logic [8:0] STD_MUL = 9'h003;
	localparam logic [8:0] STD_ADD = 9'h00B;
	localparam logic [8:0] FAST_MUL = 9'h002;
	localparam logic [8:0] FAST_ADD = 9'h009;

	typedef struct packed {
		logic [1:0] unused;
		logic peripheral_enable;
		logic general_call_enable;
		logic start_req;
		logic ack_enable;
		logic stop_req;
		logic interrupt_enable_bit;
	} i2cms_ctrl_t;

	typedef struct packed {
		logic fast_standard_select;
		logic [6:0] scl_divider_value;
	} i2cms_ccr_t;

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_RS_LO = 9'h002,
		ST_RS_HI = 9'h004,
		ST_START = 9'h008,
		ST_WAIT = 9'h010,
		ST_BIT = 9'h020,
		ST_HOLD = 9'h040,
		ST_STOP_A = 9'h080,
		ST_STOP_B = 9'h100
	} i2cms_state_t;

	typedef enum logic [2:0] {
		W_SB, W_TEN_BIT_HEADER_SENT_FLAG, W_ADDR, W_TX, W_RX
	} i2cms_wait_t;

	typedef enum logic [1:0] {
		B_ADDR1, B_ADDR2, B_DATA
	} i2cms_byte_t;

	// SCL period in clock cycles for the selected bus mode.
	function automatic logic [8:0] scl_period(input logic fs, input logic [6:0] cc);
		return fs ? ({2'h0, cc} * STD_MUL + STD_ADD) : ({2'h0, cc} * FAST_MUL + FAST_ADD);
	endfunction

endpackage

// ---- hw/i2cms_top.sv ----
// I2C master sequencer with APB register access and open-drain SDA/SCL.
// Assumes SDA/SCL inputs already synchronous to ref_clk and external pull-ups.
`timescale 1ns/1ps
module i2cms_top
	import i2cms_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [9:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic interface_interrupt_mask,
	output logic irq,
	output logic pins_alt_sel,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe
);

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	i2cms_ctrl_t ctrl_ff, nxt_ctrl;
	i2cms_ccr_t ccr_ff;
	logic [31:0] prdata_ff;
	logic [7:0] in_ff, shift_ff;
	logic sb_ff, ten_bit_header_sent_flag_ff, btf_ff, tra_ff, busy_ff, msl_ff, af_ff, arbitration_lost_flag_ff, bus_error_flag_ff;
	logic addr_ev_ff, sr1_seen_ff, irq_ff, event_flag;
	logic ev_sb_ff, ev_ten_bit_header_sent_flag_ff, ev_addr_ff, ev_btx_ff, ev_brx_ff, ev_af_ff, ev_arbitration_lost_flag_ff;
	logic ev_bus_error_flag_ff, start_clr_ff, stop_clr_ff;
	logic sda_low_ff, scl_low_ff, sda_q_ff, scl_q_ff, rx_ff, phase_ff;
	logic [3:0] bit_ff;
	logic [8:0] cnt_ff;
	i2cms_state_t state_ff;
	i2cms_wait_t wkind_ff;
	i2cms_byte_t bkind_ff;

	logic acc, wr, rd, mapped, rel_out, rel_cr, rel_in, in_wait, start_det, stop_det;
	logic stretch, adv;
	logic [8:0] period, lo_len, hi_len, lim;

	// Zero wait states keep the host handshake simple; read data is captured in setup.
	assign pready = 1'b1;
	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	assign mapped = (paddr == CR_ADDR) || (paddr == CCR_ADDR) || (paddr == IN_ADDR) ||
		(paddr == SR1_ADDR) || (paddr == SR2_ADDR) || (paddr == OUT_ADDR);
	assign pslverr = acc && !mapped;
	assign prdata = prdata_ff;
	assign event_flag = sb_ff || ten_bit_header_sent_flag_ff || btf_ff || af_ff || arbitration_lost_flag_ff || bus_error_flag_ff || addr_ev_ff;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			prdata_ff <= 32'h00000000;
		end else if (psel && !penable) begin
			case (paddr)
				CR_ADDR: prdata_ff <= {24'h000000, ctrl_ff};
				CCR_ADDR: prdata_ff <= {24'h000000, ccr_ff};
				IN_ADDR: prdata_ff <= {24'h000000, in_ff};
				SR1_ADDR: prdata_ff <= {24'h000000, event_flag, ten_bit_header_sent_flag_ff, tra_ff, busy_ff, btf_ff,
					1'b0, msl_ff, sb_ff};
				SR2_ADDR: prdata_ff <= {27'h0000000, af_ff, 1'b0, arbitration_lost_flag_ff, bus_error_flag_ff, 1'b0};
				default: prdata_ff <= 32'h00000000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Control and clock control registers
	// ------------------------------------------------------------
	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (start_clr_ff) begin
			nxt_ctrl.start_req = 1'b0;
		end
		if (stop_clr_ff) begin
			nxt_ctrl.stop_req = 1'b0;
		end
		// A software write lands after the hardware clears, so a set is never lost.
		if (wr && paddr == CR_ADDR) begin
			if (!ctrl_ff.peripheral_enable) begin
				nxt_ctrl.peripheral_enable = pwdata[PE_POS];
			end else begin
				nxt_ctrl = pwdata[7:0];
				nxt_ctrl.unused = 2'h0;
			end
		end
		if (!nxt_ctrl.peripheral_enable) begin
			nxt_ctrl = {CR_RST[7:2], nxt_ctrl.stop_req, CR_RST[0]};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ctrl_ff <= CR_RST;
			ccr_ff <= CCR_RST;
		end else begin
			ctrl_ff <= nxt_ctrl;
			if (wr && paddr == CCR_ADDR) begin
				ccr_ff <= pwdata[7:0];
			end
		end
	end

	assign pins_alt_sel = ctrl_ff.peripheral_enable;

	// ------------------------------------------------------------
	// Line monitor
	// ------------------------------------------------------------
	assign start_det = scl_q_ff && scl_in && sda_q_ff && !sda_in;
	assign stop_det = scl_q_ff && scl_in && !sda_q_ff && sda_in;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sda_q_ff <= 1'b1;
			scl_q_ff <= 1'b1;
			busy_ff <= 1'b0;
		end else begin
			sda_q_ff <= sda_in;
			scl_q_ff <= scl_in;
			if (ctrl_ff.peripheral_enable) begin
				if (start_det) begin
					busy_ff <= 1'b1;
				end else if (stop_det || ev_bus_error_flag_ff) begin
					busy_ff <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Bit timing
	// ------------------------------------------------------------
	assign period = scl_period(ccr_ff.fast_standard_select, ccr_ff.scl_divider_value);
	assign lo_len = period >> 1;
	assign hi_len = period - lo_len;
	assign lim = (state_ff == ST_BIT && phase_ff) ? hi_len : lo_len;
	// A slave holding SCL low freezes the count of the high phase.
	assign stretch = !scl_low_ff && !scl_in;
	assign adv = (cnt_ff >= lim - 9'h001) && !stretch;

	assign in_wait = state_ff == ST_WAIT;
	assign rel_out = wr && paddr == OUT_ADDR && sr1_seen_ff && in_wait &&
		(wkind_ff == W_SB || wkind_ff == W_TEN_BIT_HEADER_SENT_FLAG || wkind_ff == W_TX);
	assign rel_cr = wr && paddr == CR_ADDR && sr1_seen_ff && in_wait && wkind_ff == W_ADDR;
	assign rel_in = rd && paddr == IN_ADDR && sr1_seen_ff && in_wait && wkind_ff == W_RX;

	// ------------------------------------------------------------
	// Master sequencer
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset || !ctrl_ff.peripheral_enable) begin
			state_ff <= ST_IDLE;
			scl_low_ff <= 1'b0;
			sda_low_ff <= 1'b0;
			cnt_ff <= 9'h000;
			phase_ff <= 1'b0;
			bit_ff <= 4'h0;
			msl_ff <= 1'b0;
			rx_ff <= 1'b0;
			shift_ff <= 8'h00;
			in_ff <= 8'h00;
			wkind_ff <= W_SB;
			bkind_ff <= B_ADDR1;
			{ev_sb_ff, ev_ten_bit_header_sent_flag_ff, ev_addr_ff, ev_btx_ff, ev_brx_ff} <= 5'h00;
			{ev_af_ff, ev_arbitration_lost_flag_ff, ev_bus_error_flag_ff, start_clr_ff, stop_clr_ff} <= 5'h00;
		end else begin
			{ev_sb_ff, ev_ten_bit_header_sent_flag_ff, ev_addr_ff, ev_btx_ff, ev_brx_ff} <= 5'h00;
			{ev_af_ff, ev_arbitration_lost_flag_ff, ev_bus_error_flag_ff, start_clr_ff, stop_clr_ff} <= 5'h00;
			cnt_ff <= adv ? 9'h000 : (stretch ? cnt_ff : cnt_ff + 9'h001);
			case (state_ff)
				ST_IDLE: begin
					cnt_ff <= 9'h000;
					if (ctrl_ff.start_req && !busy_ff) begin
						msl_ff <= 1'b1;
						state_ff <= ST_RS_HI;
					end
				end
				ST_RS_LO: begin
					sda_low_ff <= 1'b0;
					if (adv) begin
						scl_low_ff <= 1'b0;
						state_ff <= ST_RS_HI;
					end
				end
				ST_RS_HI: begin
					if (adv) begin
						sda_low_ff <= 1'b1;
						state_ff <= ST_START;
					end
				end
				ST_START: begin
					if (adv) begin
						scl_low_ff <= 1'b1;
						ev_sb_ff <= 1'b1;
						start_clr_ff <= 1'b1;
						bkind_ff <= B_ADDR1;
						wkind_ff <= W_SB;
						state_ff <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					cnt_ff <= 9'h000;
					if (rel_out) begin
						shift_ff <= pwdata[7:0];
						sda_low_ff <= !pwdata[7];
						rx_ff <= 1'b0;
						bkind_ff <= (wkind_ff == W_SB) ? B_ADDR1 :
							((wkind_ff == W_TEN_BIT_HEADER_SENT_FLAG) ? B_ADDR2 : B_DATA);
						bit_ff <= 4'h0;
						phase_ff <= 1'b0;
						state_ff <= ST_BIT;
					end else if (rel_cr) begin
						if (rx_ff) begin
							sda_low_ff <= 1'b0;
							bkind_ff <= B_DATA;
							bit_ff <= 4'h0;
							phase_ff <= 1'b0;
							state_ff <= ST_BIT;
						end else begin
							wkind_ff <= W_TX;
						end
					end else if (rel_in) begin
						if (ctrl_ff.stop_req) begin
							sda_low_ff <= 1'b1;
							state_ff <= ST_STOP_A;
						end else begin
							sda_low_ff <= 1'b0;
							bit_ff <= 4'h0;
							phase_ff <= 1'b0;
							state_ff <= ST_BIT;
						end
					end else if (ctrl_ff.stop_req && wkind_ff != W_RX) begin
						sda_low_ff <= 1'b1;
						state_ff <= ST_STOP_A;
					end else if (ctrl_ff.start_req && wkind_ff != W_SB) begin
						state_ff <= ST_RS_LO;
					end
				end
				ST_BIT: begin
					if (start_det || stop_det) begin
						ev_bus_error_flag_ff <= 1'b1;
						scl_low_ff <= 1'b0;
						state_ff <= ST_HOLD;
					end else if (adv && !phase_ff) begin
						scl_low_ff <= 1'b0;
						phase_ff <= 1'b1;
					end else if (adv && !sda_low_ff && !sda_in && !rx_ff && bit_ff != LAST_BIT) begin
						ev_arbitration_lost_flag_ff <= 1'b1;
						msl_ff <= 1'b0;
						sda_low_ff <= 1'b0;
						state_ff <= ST_IDLE;
					end else if (adv) begin
						phase_ff <= 1'b0;
						scl_low_ff <= 1'b1;
						if (bit_ff != LAST_BIT) begin
							shift_ff <= {shift_ff[6:0], sda_in};
							bit_ff <= bit_ff + 4'h1;
							if (bit_ff == LAST_BIT - 4'h1) begin
								sda_low_ff <= rx_ff && ctrl_ff.ack_enable;
							end else begin
								sda_low_ff <= !rx_ff && !shift_ff[6];
							end
						end else if (!rx_ff && sda_in) begin
							ev_af_ff <= 1'b1;
							scl_low_ff <= 1'b0;
							state_ff <= ST_HOLD;
						end else begin
							sda_low_ff <= 1'b0;
							state_ff <= ST_WAIT;
							if (rx_ff) begin
								in_ff <= shift_ff;
								ev_brx_ff <= 1'b1;
								wkind_ff <= W_RX;
							end else if (bkind_ff == B_ADDR1 && shift_ff[7:3] == HDR10 &&
								!shift_ff[0]) begin
								ev_ten_bit_header_sent_flag_ff <= 1'b1;
								wkind_ff <= W_TEN_BIT_HEADER_SENT_FLAG;
							end else if (bkind_ff != B_DATA) begin
								rx_ff <= (bkind_ff == B_ADDR1) && shift_ff[0];
								ev_addr_ff <= 1'b1;
								wkind_ff <= W_ADDR;
							end else begin
								ev_btx_ff <= 1'b1;
								wkind_ff <= W_TX;
							end
						end
					end
				end
				ST_HOLD: begin
					cnt_ff <= 9'h000;
					if (ctrl_ff.start_req) begin
						scl_low_ff <= 1'b1;
						state_ff <= ST_RS_LO;
					end else if (ctrl_ff.stop_req) begin
						scl_low_ff <= 1'b1;
						sda_low_ff <= 1'b1;
						state_ff <= ST_STOP_A;
					end
				end
				ST_STOP_A: begin
					if (adv) begin
						scl_low_ff <= 1'b0;
						state_ff <= ST_STOP_B;
					end
				end
				ST_STOP_B: begin
					if (adv) begin
						sda_low_ff <= 1'b0;
						stop_clr_ff <= 1'b1;
						msl_ff <= 1'b0;
						state_ff <= ST_IDLE;
					end
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Status flags
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset || !ctrl_ff.peripheral_enable) begin
			{sb_ff, ten_bit_header_sent_flag_ff, btf_ff, tra_ff, addr_ev_ff} <= 5'h00;
			{af_ff, arbitration_lost_flag_ff, bus_error_flag_ff, sr1_seen_ff} <= 4'h0;
		end else begin
			sb_ff <= ev_sb_ff || (sb_ff && !(rel_out && wkind_ff == W_SB));
			ten_bit_header_sent_flag_ff <= ev_ten_bit_header_sent_flag_ff || (ten_bit_header_sent_flag_ff && !(rel_out && wkind_ff == W_TEN_BIT_HEADER_SENT_FLAG));
			addr_ev_ff <= ev_addr_ff || (addr_ev_ff && !rel_cr);
			btf_ff <= ev_btx_ff || ev_brx_ff || (btf_ff && !rel_out && !rel_in);
			tra_ff <= ev_btx_ff || (tra_ff && !rel_out && !rel_in && !ev_arbitration_lost_flag_ff && !stop_det);
			af_ff <= ev_af_ff || (af_ff && !(rd && paddr == SR2_ADDR));
			arbitration_lost_flag_ff <= ev_arbitration_lost_flag_ff || (arbitration_lost_flag_ff && !(rd && paddr == SR2_ADDR));
			bus_error_flag_ff <= ev_bus_error_flag_ff || (bus_error_flag_ff && !(rd && paddr == SR2_ADDR));
			sr1_seen_ff <= (rd && paddr == SR1_ADDR) || (sr1_seen_ff && !rel_out && !rel_cr &&
				!rel_in);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= event_flag && ctrl_ff.interrupt_enable_bit && interface_interrupt_mask;
		end
	end

	assign irq = irq_ff;
	assign sda_out = 1'b0;
	assign scl_out = 1'b0;
	assign sda_oe = sda_low_ff;
	assign scl_oe = scl_low_ff;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking chk_cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	chk_start_master: assert property (state_ff == ST_IDLE && ctrl_ff.start_req && !busy_ff &&
		ctrl_ff.peripheral_enable |=> msl_ff) else $error("start request did not enter master");
	chk_sb_event: assert property (ev_sb_ff && ctrl_ff.peripheral_enable |=> sb_ff && event_flag)
		else $error("start sent without start flag");
	chk_sb_hold: assert property (in_wait && wkind_ff == W_SB |-> scl_oe)
		else $error("scl released while waiting for address");
	chk_rx_hold: assert property (in_wait && wkind_ff == W_RX && !rel_in |=> scl_oe && in_wait)
		else $error("receive wait left without data read");
	chk_err_release: assert property (state_ff == ST_HOLD |-> !scl_oe)
		else $error("scl stretched in error case");
	chk_irq_gate: assert property (event_flag && ctrl_ff.interrupt_enable_bit &&
		interface_interrupt_mask |=> irq) else $error("interrupt not raised");
	chk_disable_release: assert property (!ctrl_ff.peripheral_enable [*2] |->
		!scl_oe && !sda_oe && !event_flag) else $error("outputs not released while disabled");
	chk_arbitration_lost_flag_slave: assert property ($rose(arbitration_lost_flag_ff) |-> !msl_ff)
		else $error("master kept after arbitration loss");
	chk_busy_start: assert property (start_det && ctrl_ff.peripheral_enable |=> busy_ff)
		else $error("busy not set on start");
	chk_stop_clear: assert property (state_ff == ST_STOP_B && adv |=> ##1 !ctrl_ff.stop_req)
		else $error("stop request not cleared");

endmodule

// ---- test/i2cms_slave_model.sv ----
// Behavioural I2C slave that answers the master sequencer on the bus.
// Assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/1ps
module i2cms_slave_model #(
	parameter logic [6:0] ADDR = 7'h50
) (
	input wire logic scl,
	input wire logic sda,
	input wire logic [7:0] tx_base,
	output logic sda_oe,
	output logic [7:0] last_rx,
	output logic nack_seen
);
	logic [7:0] sh = 8'h00;
	logic [7:0] tsh = 8'h00;
	logic [7:0] idx = 8'h00;
	int bits = 0;
	logic active = 1'b0;
	logic first = 1'b0;
	logic sel = 1'b0;
	logic rd = 1'b0;

	initial begin
		{sda_oe, nack_seen} = 2'h0;
		last_rx = 8'h00;
	end

	// A start restarts address decoding; a stop ends the transfer.
	// The master may move SDA in the same step as SCL falls, so SCL is looked at a little later.
	always @(negedge sda) begin
		#0.1;
		if (scl === 1'b1 && sda === 1'b0) begin
			active = 1'b1;
			first = 1'b1;
			sel = 1'b0;
			bits = 0;
			sda_oe = 1'b0;
		end
	end

	always @(posedge sda) begin
		#0.1;
		if (scl === 1'b1 && sda === 1'b1) begin
			active = 1'b0;
			sel = 1'b0;
		end
	end

	always @(posedge scl) begin
		if (active) begin
			if (bits < 8) begin
				sh = {sh[6:0], sda};
			end else if (rd && sel) begin
				nack_seen = sda;
				sel = !sda;
			end
			bits = bits + 1;
		end
	end

	// The header 11110000 is accepted too so that ten-bit sequences complete.
	always @(negedge scl) begin
		if (active) begin
			if (bits == 8) begin
				sda_oe = first ? (sh[7:1] == ADDR || sh[7:1] == 7'h78) : (sel && !rd);
				if (first) begin
					sel = sda_oe;
					rd = sh[0];
					idx = 8'h00;
				end else if (sel && !rd) begin
					last_rx = sh;
				end
				first = 1'b0;
			end else if (bits == 9) begin
				bits = 0;
				tsh = tx_base + idx;
				idx = idx + 8'h01;
				sda_oe = sel && rd && !tsh[7];
			end else if (sel && rd) begin
				sda_oe = !tsh[7 - bits];
			end
		end
	end
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench: APB tasks run master sequences against a slave model.
// Assumes pull-ups on SDA and SCL and a slave answering at address 7'h50.
`timescale 1ns/1ps
module tb_top;
	import i2cms_pkg::*;

	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [9:0] paddr = 10'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic mask = 1'b1;
	logic jam_oe = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, irq, pins_alt_sel, sda_out, sda_oe, scl_out, scl_oe;
	logic slv_oe, nack_seen, err;
	logic [7:0] last_rx;
	logic [7:0] q;
	int mismatches = 0;
	int total_checks = 0;
	int cyc = 0;
	int last_rise = 0;
	int period = 0;
	wire sda = !(sda_oe | slv_oe | jam_oe);
	wire scl = !scl_oe;

	i2cms_top i2cms_top_inst (.ref_clk(ref_clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.interface_interrupt_mask(mask), .irq(irq), .pins_alt_sel(pins_alt_sel),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .scl_in(scl),
		.scl_out(scl_out), .scl_oe(scl_oe));

	i2cms_slave_model i2cms_slave_model_inst (.scl(scl), .sda(sda), .tx_base(8'h3C),
		.sda_oe(slv_oe), .last_rx(last_rx), .nack_seen(nack_seen));

	always #2.5 ref_clk = ~ref_clk;

	always @(posedge scl) begin
		period = cyc - last_rise;
		last_rise = cyc;
	end

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	// ------------------------------------------------------------
	// Bus and check tasks
	// ------------------------------------------------------------
	task automatic check(input logic ok, input string msg);
		total_checks++;
		if (!ok) begin
			mismatches++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d,
			output logic [7:0] r);
		int n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		logic [7:0] r;
		apb(1'b1, a, d, r);
	endtask

	task automatic chk_rd(input logic [9:0] a, input logic [7:0] m, input logic [7:0] e);
		apb(1'b0, a, 8'h00, q);
		check((q & m) === e, "register read");
	endtask

	// The irq line is registered, so three edges pass before it is trusted.
	task automatic wait_irq;
		int n = 0;
		repeat (3) @(posedge ref_clk);
		while (irq !== 1'b1 && n < 3000) begin
			@(posedge ref_clk);
			n++;
		end
		check(irq === 1'b1, "no event");
	endtask

	task automatic wait_sr1(input logic [7:0] m, input logic [7:0] e);
		int n = 0;
		do begin
			apb(1'b0, SR1_ADDR, 8'h00, q);
			n++;
		end while ((q & m) !== e && n < 200);
		check((q & m) === e, "status wait");
	endtask

	// A byte-done flag left over from an earlier transfer keeps irq high, so SR1 is polled too.
	task automatic start_seq;
		wr(CR_ADDR, 8'h3D);
		wait_irq();
		wait_sr1(8'h01, 8'h01);
		chk_rd(SR1_ADDR, 8'h93, 8'h93);
	endtask

	task automatic stop_seq;
		wr(CR_ADDR, 8'h37);
		wait_sr1(8'h12, 8'h00);
		chk_rd(CR_ADDR, 8'h02, 8'h00);
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		chk_rd(CR_ADDR, 8'hFF, CR_RST);
		chk_rd(CCR_ADDR, 8'hFF, CCR_RST);
		apb(1'b0, 10'h3FC, 8'h00, q);
		check(q === 8'h00 && err === 1'b1, "unmapped read");
		wr(CR_ADDR, 8'h25);
		chk_rd(CR_ADDR, 8'hFF, 8'h20);
		check(pins_alt_sel === 1'b1, "pins not taken");
		wr(CR_ADDR, 8'h35);
		chk_rd(CR_ADDR, 8'hFF, 8'h35);
		wr(CCR_ADDR, 8'h02);
		// Seven-bit write of one byte.
		wr(CR_ADDR, 8'h3D);
		wait_irq();
		repeat (40) @(posedge ref_clk);
		check(scl_oe === 1'b1, "scl not held");
		mask <= 1'b0;
		repeat (3) @(posedge ref_clk);
		check(irq === 1'b0, "masked irq");
		mask <= 1'b1;
		chk_rd(CR_ADDR, 8'h08, 8'h00);
		chk_rd(SR1_ADDR, 8'h93, 8'h93);
		wr(OUT_ADDR, 8'hA0);
		wait_irq();
		check(period == 2 * 2 + 9, "scl period");
		chk_rd(SR1_ADDR, 8'hC3, 8'h82);
		wr(CR_ADDR, 8'h35);
		chk_rd(SR1_ADDR, 8'h02, 8'h02);
		wr(OUT_ADDR, 8'h5A);
		wait_irq();
		chk_rd(SR1_ADDR, 8'hA8, 8'hA8);
		check(last_rx === 8'h5A, "slave byte");
		stop_seq();
		// Address nobody answers.
		start_seq();
		wr(OUT_ADDR, 8'h90);
		wait_irq();
		chk_rd(SR2_ADDR, 8'h10, 8'h10);
		repeat (20) @(posedge ref_clk);
		check(scl_oe === 1'b0, "scl stretched");
		stop_seq();
		// Ten-bit address, then stop in the address wait.
		start_seq();
		wr(OUT_ADDR, 8'hF0);
		wait_irq();
		chk_rd(SR1_ADDR, 8'hC0, 8'hC0);
		wr(OUT_ADDR, 8'h00);
		wait_irq();
		chk_rd(SR1_ADDR, 8'hC3, 8'h82);
		stop_seq();
		// Two-byte read, the last one refused.
		start_seq();
		wr(OUT_ADDR, 8'hA1);
		wait_irq();
		chk_rd(SR1_ADDR, 8'hC3, 8'h82);
		wr(CR_ADDR, 8'h35);
		wait_irq();
		check(nack_seen === 1'b0, "first byte not acked");
		wr(CR_ADDR, 8'h31);
		chk_rd(SR1_ADDR, 8'hA8, 8'h88);
		chk_rd(IN_ADDR, 8'hFF, 8'h3C);
		wait_irq();
		check(nack_seen === 1'b1, "last byte acked");
		wr(CR_ADDR, 8'h33);
		chk_rd(SR1_ADDR, 8'hA8, 8'h88);
		chk_rd(IN_ADDR, 8'hFF, 8'h3D);
		wait_sr1(8'h12, 8'h00);
		// Another master holds SDA low during the address.
		start_seq();
		wr(OUT_ADDR, 8'hFE);
		jam_oe <= 1'b1;
		wait_irq();
		chk_rd(SR2_ADDR, 8'h04, 8'h04);
		chk_rd(SR1_ADDR, 8'h02, 8'h00);
		jam_oe <= 1'b0;
		wait_sr1(8'h10, 8'h00);
		// Disable with stop set.
		wr(CR_ADDR, 8'h16);
		chk_rd(CR_ADDR, 8'hFF, 8'h02);
		chk_rd(CCR_ADDR, 8'hFF, 8'h02);
		check(pins_alt_sel === 1'b0 && sda_oe === 1'b0 && scl_oe === 1'b0, "outputs");
		tally_and_finish();
	end
endmodule
